// ---- core/hbl_map.svh ----
// Constants of the host bus and link interrupt port: addresses, reset values, timing.
`ifndef HBL_MAP_SVH
`define HBL_MAP_SVH

// ************************************************
// Register addresses decoded by this port
// ************************************************
`define HBL_RX_DATA_ADDR 8'h2E
`define HBL_RX_STAT_ADDR 8'h2D
`define HBL_TX_DATA_ADDR 8'h32

// ************************************************
// Pin synchroniser layout and reset values
// ************************************************
`define HBL_SYNC_STAGES 2
`define HBL_PIN_W 22
`define HBL_PIN_RST 22'h3C0000
`define HBL_DATA_RST 8'h00

// ************************************************
// Timing
// ************************************************
`define HBL_CLK_PERIOD_NS 50
`define HBL_UDR_TIMEOUT_US 1000
`define HBL_LINK_RATE_HZ 4000
`define HBL_UDR_CNT_W 4

`endif

// ---- core/hbl_pkg.sv ----
// Types shared by the host bus and link interrupt port.
package hbl_pkg;

	// Host bus and transmit link pins after synchronisation
	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic ale;
		logic [7:0] addr;
		logic [7:0] data;
		logic link_clk;
		logic sig_in;
	} hbl_pins_t;

	// Receive link events, one-cycle pulses from the HDLC receiver
	typedef struct packed {
		logic count_hit;
		logic overrun;
		logic eom;
		logic abort;
		logic flag_start;
	} hbl_rx_evt_t;

	// Receive link configuration bits
	typedef struct packed {
		logic enable;
		logic hdlc_on;
		logic stop;
		logic irq_en;
	} hbl_rx_cfg_t;

endpackage

// ---- core/hbl_port.sv ----
// Host bus port with combined interrupt and data link service outputs.
`include "hbl_map.svh"


module hbl_port
	import hbl_pkg::*;
#(
	parameter int SRC_N = 8,
	parameter int UDR_TIMEOUT_US = `HBL_UDR_TIMEOUT_US,
	parameter int LINK_RATE_HZ = `HBL_LINK_RATE_HZ
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic reset_n_in,
	// Host bus pins
	input wire logic chip_sel_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic ale,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	// Register file side
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	output logic test_mode,
	// Combined open-drain interrupt
	input wire logic [SRC_N-1:0] irq_src,
	output logic irq_n_out,
	output logic irq_n_oe,
	// Receive link
	input wire hbl_rx_evt_t rx_evt,
	input wire hbl_rx_cfg_t rx_cfg,
	input wire logic rx_fifo_last,
	input wire logic rx_head_is_end,
	output logic rx_link_irq,
	output logic rx_link_msg_end,
	output logic rx_irq_latch,
	// Transmit link
	input wire logic tx_link_bit_clock,
	input wire logic tx_need_data,
	input wire logic tx_int_mode,
	input wire logic tx_link_signal_in,
	output logic tx_link_service_req,
	output logic tx_link_signal_oe,
	output logic tx_link_signal_level,
	output logic tx_link_underrun
);

	// ************************************************
	// Timing
	// ************************************************
	// Time-out spans UDR_TIMEOUT_US as a count of link bit periods, which scales with the link rate, raised to at least 1 and cut to its low HBL_UDR_CNT_W bits
	localparam int UDR_EDGES_I = (UDR_TIMEOUT_US * LINK_RATE_HZ) / 1000000;
	localparam logic [`HBL_UDR_CNT_W-1:0] UDR_EDGES = (UDR_EDGES_I < 1) ? `HBL_UDR_CNT_W'(1) :
		`HBL_UDR_CNT_W'(UDR_EDGES_I);

	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
		addr_is = (a == target);
	endfunction

	// ************************************************
	// Pin synchronisers
	// ************************************************
	logic rst_n_s;
	logic rst_i;
	hbl_pins_t pins_s;

	hbl_sync #(
		.W(1),
		.RST_VAL(1'b0)
	) u_rst_sync (
		.clk(clk),
		.rst(rst),
		.async_in(reset_n_in),
		.sync_out(rst_n_s)
	);

	hbl_sync #(
		.W(`HBL_PIN_W),
		.RST_VAL(`HBL_PIN_RST)
	) u_pin_sync (
		.clk(clk),
		.rst(rst),
		.async_in({chip_sel_n, read_strobe_n, write_strobe_n, ale, addr_in, data_in,
			tx_link_bit_clock, tx_link_signal_in}),
		.sync_out(pins_s)
	);

	assign rst_i = rst | ~rst_n_s;

	// ************************************************
	// Host access decode
	// ************************************************
	logic [7:0] addr_lat_r, addr_lat_nxt;
	logic [7:0] wdata_r, wdata_nxt;
	logic wcomb_d_r, wcomb_d_nxt;
	logic rcomb_d_r, rcomb_d_nxt;
	logic wr_r, wr_nxt;
	logic rd_r, rd_nxt;
	logic [7:0] dout_r, dout_nxt;
	logic doe_r, doe_nxt;
	logic test_r, test_nxt;
	logic wcomb, rcomb, wr_edge, rd_edge;

	always_comb
	begin
		wcomb = pins_s.wr_n | pins_s.cs_n;
		rcomb = pins_s.rd_n | pins_s.cs_n;
		wr_edge = wcomb & ~wcomb_d_r;
		rd_edge = ~rcomb & rcomb_d_r;
		addr_lat_nxt = pins_s.ale ? pins_s.addr : addr_lat_r;
		wdata_nxt = wr_edge ? pins_s.data : wdata_r;
		wcomb_d_nxt = wcomb;
		rcomb_d_nxt = rcomb;
		wr_nxt = wr_edge;
		rd_nxt = rd_edge;
		doe_nxt = ~rcomb;
		dout_nxt = ~rcomb ? reg_rdata : dout_r;
		test_nxt = test_r & pins_s.cs_n ? 1'b0 : test_r;
	end

	always_ff @(posedge clk)
	begin
		if (rst_i)
		begin
			addr_lat_r <= 8'h00;
			wdata_r <= `HBL_DATA_RST;
			wcomb_d_r <= 1'b1;
			rcomb_d_r <= 1'b1;
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			dout_r <= `HBL_DATA_RST;
			doe_r <= 1'b0;
			test_r <= 1'b1;
		end
		else
		begin
			addr_lat_r <= addr_lat_nxt;
			wdata_r <= wdata_nxt;
			wcomb_d_r <= wcomb_d_nxt;
			rcomb_d_r <= rcomb_d_nxt;
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			dout_r <= dout_nxt;
			doe_r <= doe_nxt;
			test_r <= test_nxt;
		end
	end

	// Access pulses per register, one per strobe
	logic rx_data_rd, rx_stat_rd, tx_data_wr;

	always_comb
	begin
		rx_data_rd = rd_edge & addr_is(addr_lat_r, `HBL_RX_DATA_ADDR);
		rx_stat_rd = rd_edge & addr_is(addr_lat_r, `HBL_RX_STAT_ADDR);
		tx_data_wr = wr_edge & addr_is(addr_lat_r, `HBL_TX_DATA_ADDR);
	end

	// ************************************************
	// Receive link interrupt and message end
	// ************************************************
	logic latch_r, latch_nxt;
	logic ovr_r, ovr_nxt;
	logic eom_r, eom_nxt;
	logic rxirq_r, rxirq_nxt;
	logic rx_active, rx_on, any_evt;

	always_comb
	begin
		rx_on = rx_cfg.enable & rx_cfg.hdlc_on;
		rx_active = rx_on & ~rx_cfg.stop;
		any_evt = rx_active & (rx_evt.count_hit | rx_evt.overrun | rx_evt.eom |
			rx_evt.abort | rx_evt.flag_start);
		// An event in the clearing cycle wins over the clear
		ovr_nxt = ovr_r;
		if (rx_stat_rd)
			ovr_nxt = 1'b0;
		if (rx_active & rx_evt.overrun)
			ovr_nxt = 1'b1;
		latch_nxt = latch_r;
		if (rx_data_rd & rx_fifo_last & ~ovr_r)
			latch_nxt = 1'b0;
		if (rx_stat_rd & ovr_r)
			latch_nxt = 1'b0;
		if (any_evt)
			latch_nxt = 1'b1;
		eom_nxt = eom_r;
		if (rx_stat_rd | ~rx_on)
			eom_nxt = 1'b0;
		if (rx_on & (rx_evt.overrun | (rx_data_rd & rx_head_is_end)))
			eom_nxt = 1'b1;
		// Mask only gates the pin; the latch stays visible
		rxirq_nxt = latch_nxt & rx_active & rx_cfg.irq_en;
	end

	always_ff @(posedge clk)
	begin
		if (rst_i)
		begin
			latch_r <= 1'b0;
			ovr_r <= 1'b0;
			eom_r <= 1'b0;
			rxirq_r <= 1'b0;
		end
		else
		begin
			latch_r <= latch_nxt;
			ovr_r <= ovr_nxt;
			eom_r <= eom_nxt;
			rxirq_r <= rxirq_nxt;
		end
	end

	// ************************************************
	// Combined interrupt pin
	// ************************************************
	logic irq_oe_r, irq_oe_nxt;
	logic irq_n_r, irq_n_nxt;

	// Pin level has its own flop so the output is not an inverter behind one
	always_comb
	begin
		irq_oe_nxt = (|irq_src) | rxirq_nxt;
		irq_n_nxt = ~irq_oe_nxt;
	end

	always_ff @(posedge clk)
	begin
		if (rst_i)
		begin
			irq_oe_r <= 1'b0;
			irq_n_r <= 1'b1;
		end
		else
		begin
			irq_oe_r <= irq_oe_nxt;
			irq_n_r <= irq_n_nxt;
		end
	end

	// ************************************************
	// Transmit link request and underrun
	// ************************************************
	logic req_r, req_nxt;
	logic udr_r, udr_nxt;
	logic [`HBL_UDR_CNT_W-1:0] cnt_r, cnt_nxt;
	logic lclk_d_r, lclk_d_nxt;
	logic sig_oe_r, sig_oe_nxt;
	logic sig_lvl_r, sig_lvl_nxt;
	logic lclk_rise;

	always_comb
	begin
		lclk_rise = pins_s.link_clk & ~lclk_d_r;
		lclk_d_nxt = pins_s.link_clk;
		req_nxt = req_r;
		if (tx_data_wr)
			req_nxt = 1'b0;
		if (tx_need_data)
			req_nxt = 1'b1;
		cnt_nxt = cnt_r;
		udr_nxt = udr_r;
		if (~req_r | tx_data_wr)
		begin
			cnt_nxt = '0;
			udr_nxt = 1'b0;
		end
		else if (lclk_rise & (cnt_r != UDR_EDGES))
			cnt_nxt = cnt_r + `HBL_UDR_CNT_W'(1);
		if (req_r & ~tx_data_wr & (cnt_r == UDR_EDGES))
			udr_nxt = 1'b1;
		sig_oe_nxt = tx_int_mode;
		sig_lvl_nxt = pins_s.sig_in;
	end

	always_ff @(posedge clk)
	begin
		if (rst_i)
		begin
			req_r <= 1'b0;
			udr_r <= 1'b0;
			cnt_r <= '0;
			lclk_d_r <= 1'b0;
			sig_oe_r <= 1'b0;
			sig_lvl_r <= 1'b1;
		end
		else
		begin
			req_r <= req_nxt;
			udr_r <= udr_nxt;
			cnt_r <= cnt_nxt;
			lclk_d_r <= lclk_d_nxt;
			sig_oe_r <= sig_oe_nxt;
			sig_lvl_r <= sig_lvl_nxt;
		end
	end

	// ************************************************
	// Outputs
	// ************************************************
	assign data_out = dout_r;
	assign data_oe = doe_r;
	assign reg_addr = addr_lat_r;
	assign reg_wdata = wdata_r;
	assign reg_wr = wr_r;
	assign reg_rd = rd_r;
	assign test_mode = test_r;
	assign irq_n_out = irq_n_r;
	assign irq_n_oe = irq_oe_r;
	assign rx_link_irq = rxirq_r;
	assign rx_link_msg_end = eom_r;
	assign rx_irq_latch = latch_r;
	assign tx_link_service_req = req_r;
	assign tx_link_signal_oe = sig_oe_r;
	assign tx_link_signal_level = sig_lvl_r;
	assign tx_link_underrun = udr_r;

endmodule // hbl_port

// ---- core/hbl_sync.sv ----
// Two-stage synchroniser for asynchronous pins.
module hbl_sync
	import hbl_pkg::*;
#(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Data
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] sync_r;
	logic [W-1:0] sync_nxt;

	// The first stage feeds only the second
	always_comb
	begin
		meta_nxt = async_in;
		sync_nxt = meta_r;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta_r <= RST_VAL;
			sync_r <= RST_VAL;
		end
		else
		begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign sync_out = sync_r;

endmodule // hbl_sync

// ---- test/hbl_host.sv ----
// Host processor model on the multiplexed register bus.
module hbl_host
(
	// Clock
	input logic clk,
	// Host bus
	output logic chip_sel_n = 1'h1,
	output logic read_strobe_n = 1'h1,
	output logic write_strobe_n = 1'h1,
	output logic ale = 1'h1,
	output logic [7:0] addr_in = 8'h00,
	output logic [7:0] bus_d = 8'h00,
	input logic [7:0] data_in,
	input logic data_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	// Select idles high from power-up so test modes clear
	// Select is always driven here, no tie to inverted reset
	task automatic acc(input logic w, input logic sel, input logic [7:0] a, input logic [7:0] d,
		output logic [8:0] q);
		@(negedge clk);
		ale = 1'h1;
		addr_in = a;
		repeat (3) @(negedge clk);
		ale = 1'h0;
		@(negedge clk);
		// Lines are reused once the address is held
		addr_in = ~a;
		bus_d = w ? d : ~bus_d;
		chip_sel_n = ~sel;
		write_strobe_n = ~w;
		read_strobe_n = w;
		repeat (4) @(negedge clk);
		q = {data_oe, data_in};
		write_strobe_n = 1'h1;
		read_strobe_n = 1'h1;
		repeat (2) @(negedge clk);
		chip_sel_n = 1'h1;
		repeat (2) @(negedge clk);
		bus_d = ~bus_d;
		repeat (3) @(negedge clk);
	endtask
endmodule // hbl_host

// ---- test/hbl_port_sva.sv ----
// Assertion checker of the host bus port.
module hbl_port_sva
	import hbl_pkg::*;
#(
	parameter int SRC_N = 8
)
(
	// Clock and reset
	input logic clk,
	input logic rst,
	// Host bus
	input logic chip_sel_n,
	input logic read_strobe_n,
	input logic [7:0] data_in,
	input logic data_oe,
	input logic [7:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	input logic test_mode,
	// Interrupts and link
	input logic [SRC_N-1:0] irq_src,
	input logic irq_n_oe,
	input hbl_rx_evt_t rx_evt,
	input hbl_rx_cfg_t rx_cfg,
	input logic rx_link_irq,
	input logic rx_link_msg_end,
	input logic tx_link_signal_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Pins pass two sync stages and one output register
	property p_irq;
		|irq_src |=> ##[0:2] irq_n_oe;
	endproperty
	a_irq: assert property (p_irq) else $error("irq pin idle");
	property p_sel;
		reg_rd || reg_wr |-> $past(!chip_sel_n, 3);
	endproperty
	a_sel: assert property (p_sel) else $error("access without select");
	property p_drive;
		data_oe |-> $past(!read_strobe_n && !chip_sel_n, 3);
	endproperty
	a_drive: assert property (p_drive) else $error("bus driven outside read");
	property p_wdata;
		reg_wr |-> reg_wdata == $past(data_in, 3);
	endproperty
	a_wdata: assert property (p_wdata) else $error("write data wrong");
	property p_rst;
		$fell(rst) |-> test_mode && !tx_link_signal_oe && !data_oe;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_off;
		!rx_cfg.enable || !rx_cfg.hdlc_on || rx_cfg.stop |=> !rx_link_irq;
	endproperty
	a_off: assert property (p_off) else $error("rx irq while off");
	property p_mask;
		!rx_cfg.irq_en |=> !rx_link_irq;
	endproperty
	a_mask: assert property (p_mask) else $error("rx irq while masked");
	property p_ovr;
		rx_evt.overrun && rx_cfg.enable && rx_cfg.hdlc_on |=> rx_link_msg_end;
	endproperty
	a_ovr: assert property (p_ovr) else $error("no end after overrun");
endmodule // hbl_port_sva
bind hbl_port hbl_port_sva #(.SRC_N(SRC_N)) u_sva (
	.clk(clk), .rst(rst), .chip_sel_n(chip_sel_n), .read_strobe_n(read_strobe_n),
	.data_in(data_in), .data_oe(data_oe), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .test_mode(test_mode), .irq_src(irq_src), .irq_n_oe(irq_n_oe),
	.rx_evt(rx_evt), .rx_cfg(rx_cfg), .rx_link_irq(rx_link_irq),
	.rx_link_msg_end(rx_link_msg_end), .tx_link_signal_oe(tx_link_signal_oe)
);

// ---- test/testbench.sv ----
// Self-checking testbench of the host bus port.
`include "hbl_map.svh"
`define CHK(n, e, g) chk(n, 16'(e), 16'(g))
module testbench
	import hbl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic reset_n_in = 1'h1;
	logic chip_sel_n, read_strobe_n, write_strobe_n, ale, data_oe, reg_wr, reg_rd, test_mode, irq_n_out, irq_n_oe;
	logic [7:0] addr_in, data_in, bus_d, data_out, reg_addr, reg_wdata, reg_rdata, a, d;
	logic [7:0] irq_src = 8'h00;
	hbl_rx_evt_t rx_evt = '0;
	hbl_rx_cfg_t rx_cfg = '0;
	logic rx_fifo_last = 1'h1;
	logic rx_head_is_end = 1'h0;
	logic rx_link_irq, rx_link_msg_end, rx_irq_latch, tx_link_service_req, tx_link_signal_oe;
	logic tx_link_signal_level, tx_link_underrun;
	logic tx_link_bit_clock = 1'h0;
	logic tx_need_data = 1'h0;
	logic tx_int_mode = 1'h0;
	logic tx_link_signal_in = 1'h1;
	logic [8:0] q;
	int bad_count = 0;
	int check_count = 0;
	int wrs = 0;
	int rds = 0;
	int m_lat = 0;
	int m_ovr = 0;
	int m_eom = 0;
	integer seed = 32'h6203913D;
	always #25 clk = ~clk;
	assign reg_rdata = reg_addr ^ 8'hA5;
	assign data_in = data_oe ? data_out : bus_d;
	hbl_port i_hbl_port (
		.clk(clk), .rst(rst), .reset_n_in(reset_n_in),
		.chip_sel_n(chip_sel_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .ale(ale),
		.addr_in(addr_in), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.test_mode(test_mode), .irq_src(irq_src), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe),
		.rx_evt(rx_evt), .rx_cfg(rx_cfg), .rx_fifo_last(rx_fifo_last), .rx_head_is_end(rx_head_is_end),
		.rx_link_irq(rx_link_irq), .rx_link_msg_end(rx_link_msg_end), .rx_irq_latch(rx_irq_latch),
		.tx_link_bit_clock(tx_link_bit_clock), .tx_need_data(tx_need_data), .tx_int_mode(tx_int_mode),
		.tx_link_signal_in(tx_link_signal_in), .tx_link_service_req(tx_link_service_req),
		.tx_link_signal_oe(tx_link_signal_oe), .tx_link_signal_level(tx_link_signal_level),
		.tx_link_underrun(tx_link_underrun)
	);
	hbl_host u_host (
		.clk(clk), .chip_sel_n(chip_sel_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
		.ale(ale), .addr_in(addr_in), .bus_d(bus_d), .data_in(data_in), .data_oe(data_oe)
	);
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic acc(input logic w, input logic sel, input logic [7:0] ad, input logic [7:0] dd);
		a = ad;
		d = dd;
		u_host.acc(w, sel, ad, dd, q);
	endtask
	task automatic link(input int n);
		repeat (n)
		begin
			tick(9);
			tx_link_bit_clock = 1'h1;
			tick(9);
			tx_link_bit_clock = 1'h0;
		end
	endtask
	task automatic rx_ev(input int k);
		rx_head_is_end = k < 3;
		m_lat = 1;
		if (k == 3)
		begin
			m_ovr = 1;
			m_eom = 1;
		end
		rx_evt = 5'h01 << k;
		tick(1);
		rx_evt = '0;
		tick(2);
	endtask
	task automatic rx_rd(input logic st);
		acc(1'h0, 1'h1, st ? `HBL_RX_STAT_ADDR : `HBL_RX_DATA_ADDR, 8'h00);
		if (st)
		begin
			m_eom = 0;
			m_lat = m_lat & ~m_ovr;
			m_ovr = 0;
		end
		else
		begin
			m_eom = m_eom | rx_head_is_end;
			m_lat = m_lat & (m_ovr | !rx_fifo_last);
		end
	endtask
	task automatic rx_chk();
		`CHK("rx_irq", m_lat & rx_cfg.irq_en, rx_link_irq);
		`CHK("rx_latch", m_lat, rx_irq_latch);
		`CHK("rx_end", m_eom, rx_link_msg_end);
	endtask
	always @(negedge clk)
	begin
		if (reg_wr === 1'h1)
		begin
			wrs++;
			`CHK("wr_word", {a, d}, {reg_addr, reg_wdata});
		end
		if (reg_rd === 1'h1)
		begin
			rds++;
			`CHK("rd_addr", a, reg_addr);
		end
	end
	initial
	begin
		tick(12);
		rst = 1'h0;
		`CHK("rst_state", 3'h5, {test_mode, tx_link_signal_oe, tx_link_signal_level});
		tick(6);
		`CHK("mode_clr", 1'h0, test_mode);
		for (int i = 1; i < 7; i++)
		begin
			acc(1'h1, 1'h1, 8'($random(seed)), 8'($random(seed)));
			acc(1'h0, 1'h1, a, 8'h00);
			`CHK("rd_data", {1'h1, a ^ 8'hA5}, q);
			`CHK("wr_cnt", i, wrs);
			`CHK("rd_cnt", i, rds);
		end
		acc(1'h1, 1'h0, 8'h11, 8'h22);
		acc(1'h0, 1'h0, 8'h11, 8'h00);
		`CHK("no_sel", 6'h30, {wrs[3:0] + rds[3:0], q[8], data_oe});
		irq_src = 8'h01 << ($random(seed) & 7);
		tick(3);
		`CHK("irq_on", 2'h1, {irq_n_out, irq_n_oe});
		irq_src = 8'h00;
		tick(3);
		`CHK("irq_off", 2'h2, {irq_n_out, irq_n_oe});
		$display("bus test done");
		rx_cfg = 4'hD;
		for (int k = 0; k < 5; k++)
		begin
			rx_ev(k);
			rx_chk();
			rx_rd(1'h0);
			rx_chk();
			rx_rd(1'h1);
			rx_chk();
		end
		rx_fifo_last = 1'h0;
		rx_ev(0);
		rx_rd(1'h0);
		rx_chk();
		rx_cfg.irq_en = 1'h0;
		tick(2);
		rx_chk();
		rx_cfg = 4'hF;
		tick(2);
		`CHK("rx_stop", 1'h0, rx_link_irq);
		rx_cfg = 4'h0;
		tick(2);
		`CHK("rx_off", 2'h0, {rx_link_irq, rx_link_msg_end});
		$display("rx test done");
		reset_n_in = 1'h0;
		tick(4);
		`CHK("pin_rst", 2'h3, {test_mode, irq_n_out});
		reset_n_in = 1'h1;
		tick(6);
		`CHK("pin_rel", 1'h0, test_mode);
		tx_int_mode = 1'h1;
		tx_need_data = 1'h1;
		tick(1);
		tx_need_data = 1'h0;
		tick(2);
		`CHK("tx_req", 2'h3, {tx_link_signal_oe, tx_link_service_req});
		tx_link_signal_in = 1'h0;
		tick(4);
		`CHK("sig_lvl", 1'h0, tx_link_signal_level);
		tx_link_signal_in = 1'h1;
		link(3);
		`CHK("udr_early", 1'h0, tx_link_underrun);
		link(1);
		tick(4);
		`CHK("udr", 1'h1, tx_link_underrun);
		acc(1'h1, 1'h1, `HBL_TX_DATA_ADDR, 8'h5A);
		`CHK("udr_clr", 2'h0, {tx_link_service_req, tx_link_underrun});
		$display("tx test done");
		stop_test();
	end
	// Whole run needs about 560 cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		stop_test();
	end
endmodule // testbench
